// *** peir_pkg.sv ***
// Package: constants and types for the endpoint interrupt request block
package peir_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] MSI_CFG_OFF = 8'h04;
  localparam logic [7:0] MSI_ADDR_LO_OFF = 8'h08;
  localparam logic [7:0] MSI_ADDR_HI_OFF = 8'h0c;
  localparam logic [7:0] MSI_DATA_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] MSG_OFF = 8'h18;
  localparam logic [7:0] COUNT_OFF = 8'h1c;
  // CTRL fields
  localparam int CTRL_MSI_EN_BIT = 0;
  localparam int CTRL_MSIX_EN_BIT = 1;
  localparam int CTRL_ENDPOINT_BIT = 2;
  localparam int CMD_INTX_DIS_BIT = 10;
  // MSI_CFG fields
  localparam int MMEN_LSB = 0;
  localparam int MMCAP_LSB = 4;
  localparam int MM_W = 3;
  // STATUS fields
  localparam int ST_INT_STATUS_BIT = 0;
  localparam int ST_INTX_ASSERTED_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_MSI_MODE_BIT = 3;
  localparam int ST_MSIX_MODE_BIT = 4;
  // Link message codes
  localparam logic [2:0] MSG_NONE = 3'h0;
  localparam logic [2:0] MSG_ASSERT_INTA = 3'h1;
  localparam logic [2:0] MSG_DEASSERT_INTA = 3'h2;
  localparam logic [2:0] MSG_MWR32 = 3'h3;
  localparam logic [2:0] MSG_MWR64 = 3'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] MMCAP_DEFAULT = 32'h0000_0005;
  // Interrupt modes
  typedef enum logic [1:0] {
    PEIR_MODE_INTX = 2'h0,
    PEIR_MODE_MSI = 2'h1,
    PEIR_MODE_MSIX = 2'h2,
    PEIR_MODE_BOTH = 2'h3
  } peir_mode_t;
endpackage

// *** peir_msg_if.sv ***
// Interface: message request from the controller to the link sender
`timescale 1ns/1ps
`default_nettype none
interface peir_msg_if;
  logic valid;
  logic ready;
  logic [2:0] kind;
  logic [63:0] addr;
  logic [31:0] data;
  modport ctrl (output valid, output kind, output addr, output data, input ready);
  modport send (input valid, input kind, input addr, input data, output ready);
endinterface
`default_nettype wire

// *** peir_link_tx.sv ***
// Link-side message sender: holds one message until the link accepts it
`timescale 1ns/1ps
`default_nettype none
module peir_link_tx
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // From controller
  peir_msg_if.send req,
  // Link side
  output logic link_valid,
  input wire logic link_ready,
  output logic [2:0] link_kind,
  output logic [63:0] link_addr,
  output logic [31:0] link_data,
  // One-cycle pulse when a message leaves
  output logic sent_pulse
);
  logic link_ready_s1_r;
  logic link_ready_s2_r;
  logic link_valid_r;
  wire take_w;
  wire done_w;

  assign take_w = req.valid && !link_valid_r;
  assign done_w = link_valid_r && link_ready_s2_r;
  assign req.ready = take_w;
  assign link_valid = link_valid_r;
  assign sent_pulse = done_w;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_ready_s1_r <= 1'b0;
      link_ready_s2_r <= 1'b0;
    end
    else
    begin
      link_ready_s1_r <= link_ready;
      link_ready_s2_r <= link_ready_s1_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_valid_r <= 1'b0;
      link_kind <= peir_pkg::MSG_NONE;
      link_addr <= 64'h0;
      link_data <= 32'h0;
    end
    else if (take_w)
    begin
      link_valid_r <= 1'b1;
      link_kind <= req.kind;
      link_addr <= req.addr;
      link_data <= req.data;
    end
    else if (done_w)
    begin
      link_valid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** peir_top.sv ***
// Endpoint interrupt request controller with APB configuration registers
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Works only when configured as endpoint
// - MSI and MSI-X enables shown continuously
// - Mode follows the two enable bits
// - Both enabled: still send MSI writes
// - Enables written only by configuration side
// - Only legacy and MSI generated here
// - MSI enabled writes; else gated legacy messages
// - Command bit 10 blocks Assert_INTA; Deassert_INTA still sent
// - INTx enabled state shown on status
// - Legacy request: sent pulse, Assert_INTA
// - Request fall sends Deassert_INTA, second pulse
// - Pending input drives interrupt status bit
// - MSI vector accepted with one write
// - MSI address and data from capability
// - 64-bit write only with nonzero upper
// - Multiple vectors only when enable nonzero
// - Vector bits replace low data bits
// - Bit count is min of capable, enable
// - Select bits beyond enabled range ignored
module peir_top
#(
  parameter int VEC_W = 32
)
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // User interrupt requests
  input wire logic user_intx_req,
  input wire logic user_intx_pending,
  input wire logic [VEC_W-1:0] user_msi_req,
  // Status to user
  output logic msi_enable,
  output logic msix_enable,
  output logic [2:0] msi_mmenable,
  output logic intx_enabled,
  output logic intx_sent,
  output logic msi_sent,
  // Link side
  output logic link_valid,
  input wire logic link_ready,
  output logic [2:0] link_kind,
  output logic [63:0] link_addr,
  output logic [31:0] link_data
);
  typedef enum logic [4:0] {
    PEIR_IDLE = 5'b00001,
    PEIR_ASRT = 5'b00010,
    PEIR_HELD = 5'b00100,
    PEIR_DEAS = 5'b01000,
    PEIR_MSI = 5'b10000
  } peir_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for user inputs from another domain
  logic intx_s1_r;
  logic intx_s2_r;
  logic pend_s1_r;
  logic pend_s2_r;
  logic [VEC_W-1:0] msi_s1_r;
  logic [VEC_W-1:0] msi_s2_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      intx_s1_r <= 1'b0;
      intx_s2_r <= 1'b0;
      pend_s1_r <= 1'b0;
      pend_s2_r <= 1'b0;
      msi_s1_r <= '0;
      msi_s2_r <= '0;
    end
    else
    begin
      intx_s1_r <= user_intx_req;
      intx_s2_r <= intx_s1_r;
      pend_s1_r <= user_intx_pending;
      pend_s2_r <= pend_s1_r;
      msi_s1_r <= user_msi_req;
      msi_s2_r <= msi_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, written only from the APB side
  logic [31:0] ctrl_r;
  logic [31:0] msi_cfg_r;
  logic [31:0] addr_lo_r;
  logic [31:0] addr_hi_r;
  logic [31:0] mdata_r;
  logic [31:0] count_r;
  logic [2:0] last_msg_r;

  wire wr_w = psel && penable && pwrite;
  wire known_w = (paddr == peir_pkg::CTRL_OFF) || (paddr == peir_pkg::MSI_CFG_OFF) ||
    (paddr == peir_pkg::MSI_ADDR_LO_OFF) || (paddr == peir_pkg::MSI_ADDR_HI_OFF) ||
    (paddr == peir_pkg::MSI_DATA_OFF) || (paddr == peir_pkg::STATUS_OFF) ||
    (paddr == peir_pkg::MSG_OFF) || (paddr == peir_pkg::COUNT_OFF);

  assign pready = 1'b1;
  assign pslverr = psel && penable && !known_w;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= peir_pkg::CTRL_RST;
      msi_cfg_r <= peir_pkg::MMCAP_DEFAULT << peir_pkg::MMCAP_LSB;
      addr_lo_r <= 32'h0;
      addr_hi_r <= 32'h0;
      mdata_r <= 32'h0;
    end
    else if (wr_w)
    begin
      if (paddr == peir_pkg::CTRL_OFF)
        ctrl_r <= pwdata;
      if (paddr == peir_pkg::MSI_CFG_OFF)
        msi_cfg_r <= pwdata;
      if (paddr == peir_pkg::MSI_ADDR_LO_OFF)
        addr_lo_r <= pwdata;
      if (paddr == peir_pkg::MSI_ADDR_HI_OFF)
        addr_hi_r <= pwdata;
      if (paddr == peir_pkg::MSI_DATA_OFF)
        mdata_r <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire endpoint_w = ctrl_r[peir_pkg::CTRL_ENDPOINT_BIT];
  wire intx_dis_w = ctrl_r[peir_pkg::CMD_INTX_DIS_BIT];
  wire [2:0] mmen_w = msi_cfg_r[peir_pkg::MMEN_LSB +: peir_pkg::MM_W];
  wire [2:0] mmcap_w = msi_cfg_r[peir_pkg::MMCAP_LSB +: peir_pkg::MM_W];
  wire [2:0] nbits_w = (mmcap_w < mmen_w) ? mmcap_w : mmen_w;
  // mode from enables; both set behaves as MSI
  wire peir_pkg::peir_mode_t mode_w = peir_pkg::peir_mode_t'({ctrl_r[peir_pkg::CTRL_MSIX_EN_BIT],
    ctrl_r[peir_pkg::CTRL_MSI_EN_BIT]});
  wire msi_mode_w = (mode_w == peir_pkg::PEIR_MODE_MSI) || (mode_w == peir_pkg::PEIR_MODE_BOTH);

  assign msi_enable = ctrl_r[peir_pkg::CTRL_MSI_EN_BIT];
  assign msix_enable = ctrl_r[peir_pkg::CTRL_MSIX_EN_BIT];
  assign msi_mmenable = mmen_w;
  assign intx_enabled = !intx_dis_w;

  ////////////////////////////////////////////////////////////////////////////
  // Vector encode: lowest set request bit becomes the vector number
  logic [4:0] vec_w;
  always_comb
  begin
    vec_w = 5'h0;
    for (int i = VEC_W - 1; i >= 0; i--)
      if (msi_s2_r[i])
        vec_w = 5'(i);
  end

  // mask vector to enabled width; zero enable gives single vector
  wire [31:0] vmask_w = (32'h1 << nbits_w) - 32'h1;
  wire [31:0] msi_payload_w = (mdata_r & ~vmask_w) | ({27'h0, vec_w} & vmask_w);
  wire wide_w = (addr_hi_r != 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Request state machine
  peir_msg_if msg ();
  logic sent_w;
  peir_state_t state_r;
  peir_state_t state_nxt;
  logic asrt_pend_r;
  logic msi_seen_r;
  logic msg_valid_w;
  logic [2:0] msg_kind_w;

  // endpoint only; no MSI-X generation here
  wire msi_new_w = endpoint_w && msi_mode_w && (msi_s2_r != '0) && !msi_seen_r;
  wire intx_new_w = endpoint_w && !msi_mode_w && intx_s2_r;

  always_comb
  begin
    state_nxt = state_r;
    msg_valid_w = 1'b0;
    msg_kind_w = peir_pkg::MSG_NONE;
    case (state_r)
      PEIR_IDLE:
      begin
        if (msi_new_w)
          state_nxt = PEIR_MSI;
        else if (intx_new_w)
          state_nxt = PEIR_ASRT;
      end
      PEIR_ASRT:
      begin
        // legacy message only while not disabled
        msg_valid_w = !intx_dis_w;
        msg_kind_w = peir_pkg::MSG_ASSERT_INTA;
        if (intx_dis_w || msg.ready)
          state_nxt = PEIR_HELD;
      end
      PEIR_HELD:
      begin
        if (!asrt_pend_r && !intx_s2_r)
          state_nxt = PEIR_DEAS;
      end
      PEIR_DEAS:
      begin
        msg_valid_w = 1'b1;
        msg_kind_w = peir_pkg::MSG_DEASSERT_INTA;
        if (msg.ready)
          state_nxt = PEIR_IDLE;
      end
      PEIR_MSI:
      begin
        msg_valid_w = 1'b1;
        msg_kind_w = wide_w ? peir_pkg::MSG_MWR64 : peir_pkg::MSG_MWR32;
        if (msg.ready)
          state_nxt = PEIR_IDLE;
      end
      default:
        state_nxt = PEIR_IDLE;
    endcase
  end

  assign msg.valid = msg_valid_w;
  assign msg.kind = msg_kind_w;
  assign msg.addr = wide_w ? {addr_hi_r, addr_lo_r} : {32'h0, addr_lo_r};
  assign msg.data = (state_r == PEIR_MSI) ? msi_payload_w : 32'h0;

  // Which kind of message is in flight decides which pulse it gives
  logic fly_msi_r;
  logic blk_pulse_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= PEIR_IDLE;
      asrt_pend_r <= 1'b0;
      msi_seen_r <= 1'b0;
      fly_msi_r <= 1'b0;
      blk_pulse_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (msg.ready)
        fly_msi_r <= (state_r == PEIR_MSI);
      blk_pulse_r <= (state_r == PEIR_ASRT) && intx_dis_w;
      // Hold until the assert is confirmed; set wins over clear
      if (msg.ready && state_r == PEIR_ASRT)
        asrt_pend_r <= 1'b1;
      else if (sent_w && !fly_msi_r)
        asrt_pend_r <= 1'b0;
      // one write per request; a new write only after all request bits return to zero
      if (state_r == PEIR_MSI && msg.ready)
        msi_seen_r <= 1'b1;
      else if (msi_s2_r == '0)
        msi_seen_r <= 1'b0;
    end
  end

  peir_link_tx u_tx
  (
    .pclk(pclk),
    .presetn(presetn),
    .req(msg),
    .link_valid(link_valid),
    .link_ready(link_ready),
    .link_kind(link_kind),
    .link_addr(link_addr),
    .link_data(link_data),
    .sent_pulse(sent_w)
  );

  // single-cycle sent pulses; a blocked assert still acknowledges
  assign intx_sent = (sent_w && !fly_msi_r) || blk_pulse_r;
  assign msi_sent = sent_w && fly_msi_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read side and message counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= 32'h0;
      last_msg_r <= peir_pkg::MSG_NONE;
    end
    else if (sent_w)
    begin
      count_r <= count_r + 32'h1;
      last_msg_r <= link_kind;
    end
  end

  wire [31:0] status_w = {27'h0, mode_w == peir_pkg::PEIR_MODE_MSIX, msi_mode_w,
    state_r != PEIR_IDLE, state_r == PEIR_HELD, pend_s2_r};

  wire [31:0] rd_w =
    (paddr == peir_pkg::CTRL_OFF) ? ctrl_r :
    (paddr == peir_pkg::MSI_CFG_OFF) ? msi_cfg_r :
    (paddr == peir_pkg::MSI_ADDR_LO_OFF) ? addr_lo_r :
    (paddr == peir_pkg::MSI_ADDR_HI_OFF) ? addr_hi_r :
    (paddr == peir_pkg::MSI_DATA_OFF) ? mdata_r :
    (paddr == peir_pkg::STATUS_OFF) ? status_w :
    (paddr == peir_pkg::MSG_OFF) ? {29'h0, last_msg_r} :
    (paddr == peir_pkg::COUNT_OFF) ? count_r : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_w;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // pulse lasts one cycle
  sent_one_a: assert property (@(posedge pclk) disable iff (!presetn)
    msi_sent |=> !msi_sent) else $error("msi_sent longer than one cycle");
  msi_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == PEIR_MSI && addr_hi_r == 32'h0) |-> msg_kind_w == peir_pkg::MSG_MWR32)
    else $error("MSI width wrong");
  intx_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (intx_dis_w && state_r == PEIR_ASRT) |-> !msg_valid_w) else $error("INTx not gated");
  endpoint_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!endpoint_w && state_r == PEIR_IDLE) |=> state_r == PEIR_IDLE) else $error("root port active");
  deassert_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == PEIR_HELD && !asrt_pend_r && !intx_s2_r) |=> state_r == PEIR_DEAS)
    else $error("no deassert");
  vec_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == PEIR_MSI |-> (msi_payload_w & ~vmask_w) == (mdata_r & ~vmask_w))
    else $error("payload high bits altered");
  // enables move only on a control write
  enable_src_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ctrl_r) |-> $past(wr_w) && $past(paddr) == peir_pkg::CTRL_OFF)
    else $error("enable bits changed without write");
  both_msi_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == PEIR_IDLE && msi_new_w && mode_w == peir_pkg::PEIR_MODE_BOTH)
    |=> state_r == PEIR_MSI) else $error("MSI dropped in both mode");
endmodule
`default_nettype wire

// *** peir_user_model.sv ***
// User-side model that raises legacy and MSI interrupt requests
`timescale 1ns/1ps
`default_nettype none
module peir_user_model
#(
  parameter int VEC_W = 32
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench commands
  input wire logic intx_go,
  input wire logic msi_go,
  input wire logic [4:0] msi_vec,
  input wire logic [VEC_W-1:0] msi_mask,
  input wire logic quit,
  // Block handshake
  input wire logic intx_sent,
  input wire logic msi_sent,
  output logic user_intx_req,
  output logic user_intx_pending,
  output logic [VEC_W-1:0] user_msi_req
);
  logic seen_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn || quit)
    begin
      user_intx_req <= 1'b0;
      user_intx_pending <= 1'b0;
      user_msi_req <= '0;
      seen_r <= 1'b0;
    end
    else
    begin
      // request and pending rise together; pending holds until quit or reset
      if (intx_go)
      begin
        user_intx_req <= 1'b1;
        user_intx_pending <= 1'b1;
        seen_r <= 1'b0;
      end
      // request falls the cycle after the first sent
      else if (intx_sent && !seen_r)
      begin
        user_intx_req <= 1'b0;
        seen_r <= 1'b1;
      end
      // the block never looks at the mask, so a masked vector is not requested
      if (msi_go && !msi_mask[msi_vec])
        user_msi_req <= VEC_W'(1) << msi_vec;
      else if (msi_sent)
        user_msi_req <= '0;
    end
  end
endmodule
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the endpoint interrupt request block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic link_ready = 1'b1;
  logic [2:0] go = 3'h0;
  logic [4:0] msi_vec = 5'h00;
  logic [31:0] msi_mask = 32'h0;
  logic [31:0] prdata, user_msi_req;
  logic pready, pslverr, user_intx_req, user_intx_pending, msi_enable, msix_enable;
  logic intx_enabled, intx_sent, msi_sent, link_valid, lv_q, is_q, ms_q;
  logic [2:0] msi_mmenable, link_kind;
  logic [63:0] link_addr;
  logic [31:0] link_data;
  logic [98:0] msgs[$];
  int n_intx = 0;
  int n_msi = 0;
  int failures = 0;
  int checks_done = 0;

  always #4 pclk = ~pclk;

  peir_top #(.VEC_W(32)) u_peir_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .user_intx_req(user_intx_req),
    .user_intx_pending(user_intx_pending), .user_msi_req(user_msi_req),
    .msi_enable(msi_enable), .msix_enable(msix_enable), .msi_mmenable(msi_mmenable),
    .intx_enabled(intx_enabled), .intx_sent(intx_sent), .msi_sent(msi_sent),
    .link_valid(link_valid), .link_ready(link_ready), .link_kind(link_kind),
    .link_addr(link_addr), .link_data(link_data));

  peir_user_model #(.VEC_W(32)) u_peir_user_model (.pclk(pclk), .presetn(presetn),
    .intx_go(go[0]), .msi_go(go[1]), .msi_vec(msi_vec), .msi_mask(msi_mask), .quit(go[2]),
    .intx_sent(intx_sent), .msi_sent(msi_sent), .user_intx_req(user_intx_req),
    .user_intx_pending(user_intx_pending), .user_msi_req(user_msi_req));

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    lv_q <= link_valid;
    is_q <= intx_sent;
    ms_q <= msi_sent;
    if (link_valid === 1'b1 && lv_q !== 1'b1)
      msgs.push_back({link_kind, link_addr, link_data});
    if (intx_sent === 1'b1)
      n_intx <= n_intx + 1;
    if (msi_sent === 1'b1)
      n_msi <= n_msi + 1;
    // a sent indication never lasts two cycles
    if ((intx_sent & is_q) === 1'b1 || (msi_sent & ms_q) === 1'b1)
      chk(64'h1, 64'h0);
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
      chk(64'h1, 64'h0);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    // The write lands at the access edge; let it settle before anyone looks
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk({32'h0, q & msk}, {32'h0, exp});
  endtask

  task automatic pulse(input int b);
    @(posedge pclk);
    go[b] <= 1'b1;
    @(posedge pclk);
    go[b] <= 1'b0;
  endtask

  // Bounded wait on a count: 0 legacy sent, 1 MSI sent, 2 link messages
  task automatic wait_til(input int which, input int n);
    int i;
    for (i = 0; i < 400; i++)
    begin
      @(posedge pclk);
      if ((which == 0 ? n_intx : which == 1 ? n_msi : msgs.size()) >= n)
        return;
    end
    chk(64'h1, 64'h0);
    wrap_up();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(peir_pkg::CTRL_OFF, 32'hffffffff, peir_pkg::CTRL_RST);
    rd_chk(peir_pkg::MSI_CFG_OFF, 32'h00000077, 32'h00000050);
    chk({61'h0, msi_enable, msix_enable, intx_enabled}, 64'h1);
  endtask

  task automatic t_intx();
    int b;
    b = n_intx;
    msgs.delete();
    link_ready <= 1'b0;
    pulse(0);
    repeat (12) @(posedge pclk);
    chk(n_intx - b, 0);
    rd_chk(peir_pkg::STATUS_OFF, 32'h1, 32'h1);
    link_ready <= 1'b1;
    wait_til(2, 2);
    wait_til(0, b + 2);
    chk(msgs[0][98:96], peir_pkg::MSG_ASSERT_INTA);
    chk(msgs[1][98:96], peir_pkg::MSG_DEASSERT_INTA);
    pulse(2);
    repeat (6) @(posedge pclk);
    rd_chk(peir_pkg::STATUS_OFF, 32'h1, 32'h0);
  endtask

  task automatic t_intx_off();
    int b;
    b = n_intx;
    msgs.delete();
    wr(peir_pkg::CTRL_OFF, 32'h00000404);
    chk(intx_enabled, 1'b0);
    pulse(0);
    wait_til(0, b + 2);
    wait_til(2, 1);
    repeat (20) @(posedge pclk);
    chk(msgs.size(), 1);
    chk(msgs[0][98:96], peir_pkg::MSG_DEASSERT_INTA);
    pulse(2);
    wr(peir_pkg::CTRL_OFF, 32'h00000004);
  endtask

  task automatic msi_one(input logic [4:0] v, input logic [2:0] k, input logic [63:0] a,
                         input logic [31:0] d);
    int b;
    b = n_msi;
    msgs.delete();
    msi_vec <= v;
    pulse(1);
    wait_til(1, b + 1);
    wait_til(2, 1);
    repeat (20) @(posedge pclk);
    chk(n_msi - b, 1);
    chk(msgs.size(), 1);
    chk(msgs[0][98:96], k);
    chk(msgs[0][95:32], a);
    chk(msgs[0][31:0], d);
  endtask

  task automatic t_msi();
    wr(peir_pkg::MSI_ADDR_LO_OFF, 32'hfee00000);
    wr(peir_pkg::MSI_ADDR_HI_OFF, 32'h00000000);
    wr(peir_pkg::MSI_DATA_OFF, 32'h12345678);
    wr(peir_pkg::CTRL_OFF, 32'h00000005);
    chk({msi_enable, msix_enable}, 2'b10);
    msi_one(5'd0, peir_pkg::MSG_MWR32, 64'hfee00000, 32'h12345678);
    wr(peir_pkg::MSI_CFG_OFF, 32'h00000055);
    chk(msi_mmenable, 3'h5);
    wr(peir_pkg::MSI_ADDR_HI_OFF, 32'h00000001);
    msi_one(5'd3, peir_pkg::MSG_MWR64, 64'h1fee00000, 32'h12345663);
    wr(peir_pkg::MSI_CFG_OFF, 32'h00000052);
    msi_one(5'd9, peir_pkg::MSG_MWR64, 64'h1fee00000, 32'h12345679);
    wr(peir_pkg::CTRL_OFF, 32'h00000007);
    chk({msi_enable, msix_enable}, 2'b11);
    msi_one(5'd2, peir_pkg::MSG_MWR64, 64'h1fee00000, 32'h1234567a);
    // A masked vector must never reach the block
    msgs.delete();
    msi_mask <= 32'h00000010;
    msi_vec <= 5'd4;
    pulse(1);
    repeat (20) @(posedge pclk);
    chk(msgs.size(), 0);
    msi_mask <= 32'h0;
  endtask

  // An MSI request in MSI-X mode and a legacy request in root port set-up must both stay silent
  task automatic t_silent();
    int k;
    for (k = 0; k < 2; k++)
    begin
      msgs.delete();
      wr(peir_pkg::CTRL_OFF, k == 0 ? 32'h00000006 : 32'h00000000);
      rd_chk(peir_pkg::STATUS_OFF, 32'h18, k == 0 ? 32'h10 : 32'h0);
      pulse(k == 0 ? 1 : 0);
      repeat (40) @(posedge pclk);
      chk(msgs.size(), 0);
      pulse(2);
      repeat (6) @(posedge pclk);
    end
    wr(peir_pkg::CTRL_OFF, 32'h00000004);
  endtask

  task automatic t_unmapped();
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({e, q}, 33'h100000000);
    wr(peir_pkg::COUNT_OFF, 32'h0);
    // Counter is read-only: seven messages went out in the earlier scenarios
    rd_chk(peir_pkg::COUNT_OFF, 32'hffffffff, 32'h00000007);
    rd_chk(peir_pkg::MSG_OFF, 32'h00000007, {29'h0, peir_pkg::MSG_MWR64});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_intx();
    t_intx_off();
    t_msi();
    t_silent();
    t_unmapped();
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
